// ===== temp_alert_pkg.sv
/*
  Shared constants, status layout, reading formats and the helper function of the
  temperature limit and alert logic.
  Assumes readings arrive as 16-bit left-justified words with 1/256 degree weight.
*/
package temp_alert_pkg;

  // ----------------------------------------------------------------------
  // Status flag layout
  // ----------------------------------------------------------------------
  localparam int STAT_W = 8;
  localparam int STAT_BUSY = 7;
  localparam int STAT_LOCAL_HIGH = 6;
  localparam int STAT_REMOTE_HIGH = 4;
  localparam int STAT_REMOTE_LOW = 3;
  localparam int STAT_DIODE_FAULT = 2;
  localparam int STAT_REMOTE_CRIT = 1;
  localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
  // Flags that may drive the alert line; busy and diode fault never do
  localparam logic [STAT_W-1:0] STAT_ALERT_SOURCES = 8'h5A;

  // ----------------------------------------------------------------------
  // Reading formats
  // ----------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int EXT_W = 18;
  localparam int FRAC_W = 8;
  localparam logic [WORD_W-1:0] RES_MASK_FILTER = 16'hFFF8;
  localparam logic [WORD_W-1:0] RES_MASK_PLAIN = 16'hFFE0;
  localparam logic signed [EXT_W-1:0] SIGNED_MAX = 18'sh07FFF;
  localparam logic signed [EXT_W-1:0] SIGNED_MIN = 18'sh38000;
  localparam logic signed [EXT_W-1:0] UNSIGNED_MAX = 18'sh0FFFF;
  localparam logic signed [EXT_W-1:0] UNSIGNED_MIN = 18'sh00000;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  // Widens a reading or limit word to the common comparison range
  function automatic logic signed [EXT_W-1:0] to_ext(input logic [WORD_W-1:0] w,
                                                     input logic unsigned_fmt);
    to_ext = unsigned_fmt ? $signed({2'b00, w}) : $signed({{2{w[WORD_W-1]}}, w});
  endfunction

endpackage

// ===== reading_if.sv
/*
  Carrier between the alert top and its offset corrector and limit comparator.
  Assumes the top drives all raw inputs from its own clock domain.
*/
`timescale 1ns/1ns
interface reading_if;
  import temp_alert_pkg::*;
  logic [WORD_W-1:0] raw_word;
  logic [WORD_W-1:0] offset_word;
  logic [WORD_W-1:0] corrected_word;
  logic unsigned_fmt;
  logic filter_en;
  logic [WORD_W-1:0] high_limit;
  logic [WORD_W-1:0] low_limit;
  logic [7:0] crit_limit;
  logic [7:0] crit_hyst;
  logic above_high;
  logic below_low;
  logic above_crit;
  logic crit_release;

  modport corrector (input raw_word, offset_word, unsigned_fmt, filter_en,
                     output corrected_word);
  modport comparator (input corrected_word, unsigned_fmt, high_limit, low_limit,
                      crit_limit, crit_hyst,
                      output above_high, below_low, above_crit, crit_release);
  modport owner (output raw_word, offset_word, unsigned_fmt, filter_en, high_limit,
                 low_limit, crit_limit, crit_hyst,
                 input corrected_word, above_high, below_low, above_crit, crit_release);
endinterface

// ===== remote_offset_corrector.sv
/*
  Adds the signed offset to the raw remote reading, clamps and trims resolution.
  Assumes a purely combinational path; the top registers the result.
*/
`timescale 1ns/1ns
module remote_offset_corrector
  import temp_alert_pkg::*;
(
  reading_if.corrector rd
);

  logic signed [EXT_W-1:0] sum;
  logic signed [EXT_W-1:0] clamped;
  logic signed [EXT_W-1:0] hi_bound;
  logic signed [EXT_W-1:0] lo_bound;

  // ----------------------------------------------------------------------
  // Correction and clamp
  // ----------------------------------------------------------------------
  always_comb begin
    sum = to_ext(rd.raw_word, rd.unsigned_fmt) + to_ext(rd.offset_word, 1'b0); // RULE_18
    hi_bound = rd.unsigned_fmt ? UNSIGNED_MAX : SIGNED_MAX; // RULE_17
    lo_bound = rd.unsigned_fmt ? UNSIGNED_MIN : SIGNED_MIN;
    // Clamped rather than wrapped so a hot diode never reads as cold
    if (sum > hi_bound) begin
      clamped = hi_bound;
    end else if (sum < lo_bound) begin
      clamped = lo_bound;
    end else begin
      clamped = sum;
    end
  end

  assign rd.corrected_word = clamped[WORD_W-1:0] &
                             (rd.filter_en ? RES_MASK_FILTER : RES_MASK_PLAIN); // RULE_16 RULE_17

endmodule

// ===== remote_limit_comparator.sv
/*
  Compares the corrected remote reading with the high, low and critical limits.
  Assumes limits share the reading's signed or unsigned format.
*/
`timescale 1ns/1ns
module remote_limit_comparator
  import temp_alert_pkg::*;
(
  reading_if.comparator rd
);

  logic signed [EXT_W-1:0] reading_x;
  logic signed [EXT_W-1:0] crit_x;
  logic signed [EXT_W-FRAC_W:0] release_whole;
  logic signed [EXT_W-FRAC_W:0] reading_whole;

  // ----------------------------------------------------------------------
  // Limit tests
  // ----------------------------------------------------------------------
  always_comb begin
    reading_x = to_ext(rd.corrected_word, rd.unsigned_fmt); // RULE_07
    crit_x = to_ext({rd.crit_limit, FRAC_ZERO}, rd.unsigned_fmt);
    // Whole-degree view: arithmetic floor of the fractional reading
    reading_whole = $signed({reading_x[EXT_W-1], reading_x[EXT_W-1:FRAC_W]});
    release_whole = $signed({crit_x[EXT_W-1], crit_x[EXT_W-1:FRAC_W]}) -
                    $signed({3'b000, rd.crit_hyst});
  end

  assign rd.above_high = reading_x > to_ext(rd.high_limit, rd.unsigned_fmt); // RULE_21
  assign rd.below_low = reading_x < to_ext(rd.low_limit, rd.unsigned_fmt); // RULE_21
  assign rd.above_crit = reading_x > crit_x; // RULE_05 RULE_21
  assign rd.crit_release = reading_whole <= release_whole; // RULE_19

endmodule

// ===== temp_limit_alert_logic.sv
/*
  Top of the temperature limit and alert logic: holds readings, limits,
  status flags, the alert mask and the two open-drain output drives.
  Assumes configuration, limit writes and status reads come from a register
  port on the same clock, and that conversion_done is a one-cycle pulse.
*/
`timescale 1ns/1ns

// How it works
// (RULE_01) On each finished conversion, compare local and remote readings with their limits.
// (RULE_02) Out-of-limit readings set their matching status flag.
// (RULE_03) Unmasked set flags, except busy and diode fault, pull alert low.
// (RULE_04) Alert and critical outputs only pull low, otherwise float.
// (RULE_05) Critical output asserts when remote reading exceeds critical limit.
// (RULE_06) Critical hysteresis and fan-table hysteresis are separate registers.
// (RULE_07) Unsigned select picks signed or unsigned remote comparisons.
// (RULE_08) Comparator mode releases alert once the condition clears, no software.
// (RULE_09) In interrupt mode a status read with alert flags sets the mask.
// (RULE_10) Status flags clear only through a host status read; the remote critical flag also clears at its release point. Busy tracks conversion_busy.
// (RULE_11) Flags set again at the next conversion if still out of limit.
// (RULE_12) That status read also clears flags and releases alert.
// (RULE_13) Alerts are generated only while the mask bit holds zero.
// (RULE_14) Host reads status and services it before clearing the mask.
// (RULE_15) Standby halts conversions; a second bit decides whether PWM runs.
// (RULE_16) Local values are 8 bits; remote reading is a left-justified 16-bit word.
// (RULE_17) Filtered remote readings keep 13 bits; unsigned format reaches above 127.
// (RULE_18) A signed offset is added to remote readings before reporting and comparing.
// (RULE_19) Critical flag and output release at limit minus hysteresis, whole degrees.
// (RULE_20) Critical limit stays at default until the override bit is set.
// (RULE_21) Comparisons are strict; equal to a limit never trips.
// (RULE_22) Mask, comparator mode and flags reset to zero: interrupt mode, enabled.
module temp_limit_alert_logic
  import temp_alert_pkg::*;
#(
  parameter logic [7:0] CRIT_LIMIT_RESET = 8'h64,
  parameter logic [7:0] CRIT_HYST_RESET = 8'h0A,
  parameter logic [7:0] LUT_HYST_RESET = 8'h04
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic conversion_done,
  input wire logic conversion_busy,
  input wire logic [7:0] local_raw,
  input wire logic [WORD_W-1:0] remote_raw,
  input wire logic remote_diode_fault,
  input wire logic status_read,
  input wire logic alert_mask_write,
  input wire logic alert_mask_wdata,
  input wire logic comparator_mode,
  input wire logic unsigned_format_select,
  input wire logic remote_filter_enable,
  input wire logic standby,
  input wire logic pwm_disable_in_standby,
  input wire logic critical_limit_override,
  input wire logic [7:0] local_high_limit,
  input wire logic [WORD_W-1:0] remote_high_limit,
  input wire logic [WORD_W-1:0] remote_low_limit,
  input wire logic crit_limit_write,
  input wire logic [7:0] crit_limit_wdata,
  input wire logic crit_hyst_write,
  input wire logic [7:0] crit_hyst_wdata,
  input wire logic lut_hyst_write,
  input wire logic [7:0] lut_hyst_wdata,
  input wire logic [7:0] remote_offset_high_byte,
  input wire logic [7:0] remote_offset_low_byte,
  output logic [7:0] local_reading,
  output logic [7:0] remote_reading_high,
  output logic [7:0] remote_reading_low,
  output logic [STAT_W-1:0] alert_status,
  output logic [STAT_W-1:0] status_read_data,
  output logic alert_mask,
  output logic [7:0] remote_critical_limit,
  output logic [7:0] crit_hysteresis,
  output logic [7:0] lut_hysteresis,
  output logic conversions_enabled,
  output logic pwm_enabled,
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic crit_temp_n_out,
  output logic crit_temp_n_oe
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] local_reading;
    logic [WORD_W-1:0] remote_reading;
    logic [STAT_W-1:0] flags;
    logic [STAT_W-1:0] cond;
    logic [STAT_W-1:0] read_data;
    logic mask;
    logic crit_active;
    logic [7:0] crit_limit;
    logic [7:0] crit_hyst;
    logic [7:0] lut_hyst;
    logic conv_en;
    logic pwm_en;
    logic alert_oe;
    logic crit_oe;
    logic alert_level;
    logic crit_level;
  } state_t;

  localparam state_t STATE_RESET = '{
    local_reading: BYTE_ZERO,
    remote_reading: WORD_ZERO,
    flags: STAT_RESET,
    cond: STAT_RESET,
    read_data: STAT_RESET,
    mask: 1'b0,
    crit_active: 1'b0,
    crit_limit: CRIT_LIMIT_RESET,
    crit_hyst: CRIT_HYST_RESET,
    lut_hyst: LUT_HYST_RESET,
    conv_en: 1'b1,
    pwm_en: 1'b1,
    alert_oe: 1'b0,
    crit_oe: 1'b0,
    alert_level: 1'b0,
    crit_level: 1'b0
  };

  state_t s_q;
  state_t s_d;

  // ----------------------------------------------------------------------
  // Remote path: offset correction and limit comparison
  // ----------------------------------------------------------------------
  reading_if rd ();

  assign rd.raw_word = remote_raw;
  assign rd.offset_word = {remote_offset_high_byte, remote_offset_low_byte};
  assign rd.unsigned_fmt = unsigned_format_select;
  assign rd.filter_en = remote_filter_enable;
  assign rd.high_limit = remote_high_limit;
  assign rd.low_limit = remote_low_limit;
  assign rd.crit_limit = s_q.crit_limit;
  assign rd.crit_hyst = s_q.crit_hyst;

  remote_offset_corrector u_corrector (
    .rd(rd.corrector)
  );

  remote_limit_comparator u_comparator (
    .rd(rd.comparator)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic take_conv;
  logic local_above;
  logic [STAT_W-1:0] set_vec;
  logic [STAT_W-1:0] clr_vec;
  logic [STAT_W-1:0] cond_now;
  logic alert_any;

  always_comb begin
    s_d = s_q;
    set_vec = STAT_RESET;
    clr_vec = STAT_RESET;
    cond_now = s_q.cond;
    alert_any = 1'b0;

    // Conversions stop in standby; a late done pulse is dropped
    take_conv = conversion_done & s_q.conv_en; // RULE_15
    local_above = $signed(local_raw) > $signed(local_high_limit); // RULE_01 RULE_21

    // Standby and PWM gating
    s_d.conv_en = ~standby; // RULE_15
    s_d.pwm_en = ~(standby & pwm_disable_in_standby); // RULE_15

    // Readings are latched only at the end of a conversion
    if (take_conv) begin
      s_d.local_reading = local_raw; // RULE_16
      s_d.remote_reading = rd.corrected_word; // RULE_16 RULE_18
    end

    // Limit registers; critical limit locked until override
    if (crit_limit_write && critical_limit_override) begin
      s_d.crit_limit = crit_limit_wdata; // RULE_20
    end
    if (crit_hyst_write) begin
      s_d.crit_hyst = crit_hyst_wdata; // RULE_06
    end
    if (lut_hyst_write) begin
      s_d.lut_hyst = lut_hyst_wdata; // RULE_06
    end

    // Critical output state with hysteresis
    if (take_conv) begin
      if (rd.above_crit) begin
        s_d.crit_active = 1'b1; // RULE_05
      end else if (rd.crit_release) begin
        s_d.crit_active = 1'b0; // RULE_19
      end
    end

    // Live out-of-limit view, refreshed each conversion
    if (take_conv) begin
      cond_now = STAT_RESET;
      cond_now[STAT_LOCAL_HIGH] = local_above; // RULE_01
      cond_now[STAT_REMOTE_HIGH] = rd.above_high; // RULE_01
      cond_now[STAT_REMOTE_LOW] = rd.below_low; // RULE_01
      cond_now[STAT_REMOTE_CRIT] = s_d.crit_active; // RULE_01
      cond_now[STAT_DIODE_FAULT] = remote_diode_fault;
    end
    s_d.cond = cond_now;

    // Sticky flag events from this conversion
    if (take_conv) begin
      set_vec[STAT_LOCAL_HIGH] = local_above; // RULE_02
      set_vec[STAT_REMOTE_HIGH] = rd.above_high; // RULE_02
      set_vec[STAT_REMOTE_LOW] = rd.below_low; // RULE_02
      set_vec[STAT_REMOTE_CRIT] = rd.above_crit; // RULE_02
      set_vec[STAT_DIODE_FAULT] = remote_diode_fault; // RULE_02
      clr_vec[STAT_REMOTE_CRIT] = ~rd.above_crit & rd.crit_release; // RULE_19
    end

    // Status read returns the flags and clears them
    if (status_read) begin
      s_d.read_data = s_q.flags;
      s_d.read_data[STAT_BUSY] = conversion_busy;
      clr_vec = ~STAT_RESET; // RULE_10 RULE_12
      if (!comparator_mode && |(s_q.flags & STAT_ALERT_SOURCES)) begin
        s_d.mask = 1'b1; // RULE_09
      end
    end

    // A conversion event in the clearing cycle survives the read
    s_d.flags = (s_q.flags & ~clr_vec) | set_vec; // RULE_10 RULE_11
    s_d.flags[STAT_BUSY] = conversion_busy;

    // Software mask write; the read-induced set takes priority
    if (alert_mask_write && !s_d.mask) begin
      s_d.mask = alert_mask_wdata; // RULE_13
    end else if (alert_mask_write && !(status_read && !comparator_mode)) begin
      s_d.mask = alert_mask_wdata; // RULE_13
    end

    // Alert source: live condition or sticky flags, depending on mode
    if (comparator_mode) begin
      alert_any = |(s_d.cond & STAT_ALERT_SOURCES); // RULE_08
    end else begin
      alert_any = |(s_d.flags & STAT_ALERT_SOURCES); // RULE_03 RULE_12
    end
    s_d.alert_oe = alert_any & ~s_d.mask; // RULE_03 RULE_13
    s_d.crit_oe = s_d.crit_active; // RULE_05

    // Open-drain drive level is always low; only the enable moves
    s_d.alert_level = 1'b0; // RULE_04
    s_d.crit_level = 1'b0; // RULE_04
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= STATE_RESET; // RULE_22
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign local_reading = s_q.local_reading;
  assign remote_reading_high = s_q.remote_reading[WORD_W-1:8];
  assign remote_reading_low = s_q.remote_reading[7:0];
  assign alert_status = s_q.flags;
  assign status_read_data = s_q.read_data;
  assign alert_mask = s_q.mask;
  assign remote_critical_limit = s_q.crit_limit;
  assign crit_hysteresis = s_q.crit_hyst;
  assign lut_hysteresis = s_q.lut_hyst;
  assign conversions_enabled = s_q.conv_en;
  assign pwm_enabled = s_q.pwm_en;
  assign alert_n_out = s_q.alert_level;
  assign alert_n_oe = s_q.alert_oe;
  assign crit_temp_n_out = s_q.crit_level;
  assign crit_temp_n_oe = s_q.crit_oe;

endmodule

// ===== temp_alert_properties.sv
/*
  Port checker of the temperature alert top.
  Assumes one clock domain and a bind made by name.
*/
`timescale 1ns/1ns
module temp_alert_properties
  import temp_alert_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic conversion_done,
  input wire logic status_read,
  input wire logic alert_mask_write,
  input wire logic alert_mask_wdata,
  input wire logic comparator_mode,
  input wire logic standby,
  input wire logic pwm_disable_in_standby,
  input wire logic [STAT_W-1:0] alert_status,
  input wire logic alert_mask,
  input wire logic conversions_enabled,
  input wire logic pwm_enabled,
  input wire logic alert_n_out,
  input wire logic alert_n_oe,
  input wire logic crit_temp_n_out,
  input wire logic crit_temp_n_oe
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Alert and critical drives, flags, mask and standby gating
  // ------------------------------------------------------------
  open_drain_low_a: assert property (!alert_n_out && !crit_temp_n_out)
    else $error("open drain level not low");
  mask_blocks_a: assert property (alert_mask |-> !alert_n_oe)
    else $error("alert driven while masked");
  // Mode switch guarded: the drive may lag a mode change by a cycle
  source_drives_a: assert property (!comparator_mode
    && $stable(comparator_mode) && !alert_mask
    && (alert_status & STAT_ALERT_SOURCES) != 8'h00 |-> alert_n_oe)
    else $error("alert not driven");
  no_source_a: assert property (!comparator_mode && $stable(comparator_mode)
    && (alert_status & STAT_ALERT_SOURCES) == 8'h00 |-> !alert_n_oe)
    else $error("alert driven without source");
  flags_hold_a: assert property (!status_read && !conversion_done |=>
    $stable(alert_status[6:1]))
    else $error("flags changed without cause");
  read_clears_a: assert property (status_read && !conversion_done |=>
    (alert_status & 8'h7F) == 8'h00)
    else $error("flags left after read");
  read_masks_a: assert property (status_read && !comparator_mode
    && (alert_status & STAT_ALERT_SOURCES) != 8'h00 |=> alert_mask)
    else $error("mask not set by read");
  mask_write_a: assert property (alert_mask_write && !status_read |=>
    alert_mask == $past(alert_mask_wdata))
    else $error("mask write lost");
  standby_gate_a: assert property (1'b1 |=> conversions_enabled == !$past(standby)
    && pwm_enabled == !($past(standby) && $past(pwm_disable_in_standby)))
    else $error("standby gating wrong");
  crit_timing_a: assert property ($changed(crit_temp_n_oe) |-> $past(conversion_done))
    else $error("critical drive moved between conversions");
  cover property (status_read && alert_n_oe);
  cover property ($fell(alert_n_oe) && comparator_mode);
  cover property ($rose(crit_temp_n_oe));
endmodule

// ===== alert_host_model.sv
/*
  Host that services the alert line: reads status, then re-enables alerts.
  Assumes the line is pulled up and sampled on the block's clock.
*/
`timescale 1ns/1ns
module alert_host_model #(
  parameter int SERVICE_CYCLES = 4
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic service_en,
  input wire logic alert_line,
  output logic status_read,
  output logic mask_write,
  output logic mask_wdata,
  output int services
);
  int wait_q;
  assign mask_wdata = 1'b0;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_read <= 1'b0;
      mask_write <= 1'b0;
      wait_q <= 0;
      services <= 0;
    end else begin
      status_read <= 1'b0;
      mask_write <= 1'b0;
      // Status read first; the mask is cleared only after servicing
      if (wait_q == 0 && service_en && !alert_line) begin
        status_read <= 1'b1;
        wait_q <= SERVICE_CYCLES;
      end else if (wait_q == 1) begin
        mask_write <= 1'b1;
        services <= services + 1;
        wait_q <= 0;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule

// ===== temp_limit_alert_logic_tb_top.sv
/*
  Self-checking bench of the temperature alert top with a host model.
  Assumes inputs change 1 ns after the rising edge.
*/
`timescale 1ns/1ns
module temp_limit_alert_logic_tb_top;
  import temp_alert_pkg::*;
  localparam logic [7:0] CL = 8'h64;
  localparam logic [7:0] CH = 8'h0A;
  localparam logic [7:0] LH = 8'h04;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic conversion_done, conversion_busy, remote_diode_fault, alert_mask_write;
  logic alert_mask_wdata, comparator_mode, unsigned_format_select, remote_filter_enable;
  logic standby, pwm_disable_in_standby, critical_limit_override, crit_limit_write;
  logic crit_hyst_write, lut_hyst_write, tb_read, h_read, h_mw, h_md, service_en;
  logic [7:0] local_raw, local_high_limit, crit_limit_wdata, crit_hyst_wdata;
  logic [7:0] lut_hyst_wdata, remote_offset_high_byte, remote_offset_low_byte;
  logic [7:0] local_reading, remote_reading_high, remote_reading_low;
  logic [7:0] remote_critical_limit, crit_hysteresis, lut_hysteresis;
  logic [WORD_W-1:0] remote_raw, remote_high_limit, remote_low_limit;
  logic [STAT_W-1:0] alert_status, status_read_data;
  logic alert_mask, conversions_enabled, pwm_enabled, alert_n_out, alert_n_oe;
  logic crit_temp_n_out, crit_temp_n_oe;
  int services;
  int bad_count = 0;
  int comparisons = 0;
  // Pull-up on the shared alert line
  wire logic alert_line = alert_n_oe ? alert_n_out : 1'b1;
  always #4 clk_sys = ~clk_sys;
  temp_limit_alert_logic #(.CRIT_LIMIT_RESET(CL), .CRIT_HYST_RESET(CH), .LUT_HYST_RESET(LH))
    dut (.status_read(tb_read | h_read), .alert_mask_write(alert_mask_write | h_mw),
    .alert_mask_wdata(h_mw ? h_md : alert_mask_wdata), .*);
  alert_host_model host (.clk_sys(clk_sys), .resetn(resetn), .service_en(service_en),
    .alert_line(alert_line), .status_read(h_read), .mask_write(h_mw), .mask_wdata(h_md),
    .services(services));
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic conv(input logic [7:0] l, input logic [15:0] r, input logic [7:0] exp);
    local_raw = l;
    remote_raw = r;
    conversion_done = 1'b1;
    tick();
    conversion_done = 1'b0;
    check("status", alert_status, exp);
    tick();
  endtask
  task automatic rd(input logic [7:0] exp);
    tb_read = 1'b1;
    tick();
    tb_read = 1'b0;
    check("read data", status_read_data, exp);
  endtask
  task automatic wmask(input logic v);
    alert_mask_write = 1'b1;
    alert_mask_wdata = v;
    tick();
    alert_mask_write = 1'b0;
    check("mask", alert_mask, v);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {conversion_done, conversion_busy, remote_diode_fault, alert_mask_write} = '0;
    {alert_mask_wdata, comparator_mode, unsigned_format_select, remote_filter_enable} = '0;
    {standby, pwm_disable_in_standby, critical_limit_override, crit_limit_write} = '0;
    {crit_hyst_write, lut_hyst_write, tb_read, service_en} = '0;
    {local_raw, crit_limit_wdata, crit_hyst_wdata, lut_hyst_wdata} = '0;
    {remote_offset_high_byte, remote_offset_low_byte, remote_raw} = '0;
    local_high_limit = 8'h46;
    remote_high_limit = 16'h5000;
    remote_low_limit = 16'h0A00;
    tick(8);
    resetn = 1'b1;
    check("rst flags", {alert_mask, alert_n_oe, alert_status}, 10'h000);
    check("rst limits", {remote_critical_limit, crit_hysteresis}, {CL, CH});
    check("rst gates", {conversions_enabled, pwm_enabled}, 2'b11);
    conv(8'h19, 16'h1900, 8'h00);
    check("readings", {local_reading, remote_reading_high, remote_reading_low}, 24'h191900);
    conv(8'h46, 16'h5000, 8'h00);
    conv(8'h46, 16'h0A00, 8'h00);
    conv(8'h47, 16'h5020, 8'h50);
    check("oe", alert_n_oe, 1'b1);
    conversion_busy = 1'b1;
    tick();
    rd(8'hD0);
    check("after read", {alert_mask, alert_n_oe, alert_status}, 10'h280);
    conversion_busy = 1'b0;
    conv(8'h47, 16'h5020, 8'h50);
    check("masked oe", alert_n_oe, 1'b0);
    wmask(1'b0);
    check("unmasked oe", alert_n_oe, 1'b1);
    rd(8'h50);
    wmask(1'b0);
    remote_diode_fault = 1'b1;
    conv(8'h19, 16'h1900, 8'h04);
    remote_diode_fault = 1'b0;
    check("fault oe", alert_n_oe, 1'b0);
    rd(8'h04);
    check("fault mask", alert_mask, 1'b0);
    conv(8'h19, 16'h09FF, 8'h08);
    check("plain res", remote_reading_low, 8'hE0);
    remote_filter_enable = 1'b1;
    conv(8'h19, 16'h09FF, 8'h08);
    check("filter res", remote_reading_low, 8'hF8);
    remote_filter_enable = 1'b0;
    rd(8'h08);
    wmask(1'b0);
    remote_offset_high_byte = 8'h01;
    remote_offset_low_byte = 8'h80;
    conv(8'h19, 16'h1900, 8'h00);
    check("offset", {remote_reading_high, remote_reading_low}, 16'h1A80);
    remote_offset_high_byte = 8'hFF;
    remote_offset_low_byte = 8'h00;
    conv(8'h19, 16'h0A00, 8'h08);
    remote_offset_high_byte = 8'h00;
    rd(8'h08);
    wmask(1'b0);
    conv(8'h19, 16'h6400, 8'h10);
    check("crit equal", crit_temp_n_oe, 1'b0);
    conv(8'h19, 16'hC900, 8'h18);
    rd(8'h18);
    wmask(1'b0);
    unsigned_format_select = 1'b1;
    conv(8'h19, 16'hC900, 8'h12);
    check("crit on", crit_temp_n_oe, 1'b1);
    rd(8'h12);
    wmask(1'b0);
    conv(8'h19, 16'h5B00, 8'h10);
    check("crit held", crit_temp_n_oe, 1'b1);
    conv(8'h19, 16'h5A80, 8'h10);
    check("crit off", crit_temp_n_oe, 1'b0);
    unsigned_format_select = 1'b0;
    rd(8'h10);
    wmask(1'b0);
    crit_limit_wdata = 8'h50;
    crit_limit_write = 1'b1;
    tick();
    check("locked", remote_critical_limit, CL);
    critical_limit_override = 1'b1;
    tick();
    crit_limit_write = 1'b0;
    crit_hyst_wdata = 8'h05;
    crit_hyst_write = 1'b1;
    tick();
    crit_hyst_write = 1'b0;
    check("crit set", {remote_critical_limit, crit_hysteresis, lut_hysteresis}, 24'h500504);
    lut_hyst_wdata = 8'h07;
    lut_hyst_write = 1'b1;
    tick();
    lut_hyst_write = 1'b0;
    check("lut hyst", {crit_hysteresis, lut_hysteresis}, 16'h0507);
    conv(8'h19, 16'h5080, 8'h12);
    rd(8'h12);
    wmask(1'b0);
    comparator_mode = 1'b1;
    tick();
    conv(8'h47, 16'h1900, 8'h40);
    check("cmp on", alert_n_oe, 1'b1);
    conv(8'h19, 16'h1900, 8'h40);
    check("cmp off", alert_n_oe, 1'b0);
    rd(8'h40);
    check("cmp mask", alert_mask, 1'b0);
    comparator_mode = 1'b0;
    standby = 1'b1;
    pwm_disable_in_standby = 1'b1;
    tick();
    check("standby", {conversions_enabled, pwm_enabled}, 2'b00);
    conv(8'h47, 16'h1900, 8'h00);
    {standby, pwm_disable_in_standby} = 2'b00;
    service_en = 1'b1;
    tick();
    conv(8'h47, 16'h1900, 8'h40);
    for (int i = 0; i < 50 && services == 0; i++)
      tick();
    tick(2);
    check("services", 16'(services), 16'h0001);
    check("serviced", {alert_mask, alert_status}, 9'h000);
    stop_test();
  end
endmodule
bind temp_limit_alert_logic temp_alert_properties u_props (.*);
